// *** rtl/smd_defines.svh ***
`ifndef SMD_DEFINES_SVH
`define SMD_DEFINES_SVH

// operand and result widths
`define SMD_BYTE_W        8
`define SMD_WORD_W        16
`define SMD_DVD_W         32

// divide runs one quotient bit per clock over the whole widened dividend
`define SMD_DIV_STEPS     32

// interrupt vector raised on a zero divisor or a quotient that does not fit
`define SMD_DIV_ERR_VEC   8'h00

// largest quotient magnitude that still fits, per width and sign
`define SMD_QMAX_POS_B    32'h0000007f
`define SMD_QMAX_NEG_B    32'h00000080
`define SMD_QMAX_POS_W    32'h00007fff
`define SMD_QMAX_NEG_W    32'h00008000

// reset values
`define SMD_RST_WORD      16'h0000
`define SMD_RST_VEC       8'h00

`endif

// *** rtl/smd_pkg.sv ***
`include "smd_defines.svh"

package smd_pkg;

    typedef enum logic [2:0] {
        SMD_OP_DIV_B    = 3'h0,
        SMD_OP_DIV_W    = 3'h1,
        SMD_OP_MUL1_B   = 3'h2,
        SMD_OP_MUL1_W   = 3'h3,
        SMD_OP_MUL2_I8  = 3'h4,
        SMD_OP_MUL2_I16 = 3'h5,
        SMD_OP_MUL3_I8  = 3'h6,
        SMD_OP_MUL3_I16 = 3'h7
    } smd_op_t;

    typedef enum logic [3:0] {
        SMD_ST_IDLE = 4'b0001,
        SMD_ST_MUL  = 4'b0010,
        SMD_ST_DIV  = 4'b0100,
        SMD_ST_ZERO = 4'b1000
    } smd_state_t;

    // request from decoder and register file
    typedef struct packed {
        smd_op_t                  op;
        logic [`SMD_WORD_W-1:0]   accumulator_word;
        logic [`SMD_WORD_W-1:0]   data_extension_word;
        logic [`SMD_WORD_W-1:0]   src;
        logic [`SMD_WORD_W-1:0]   dst;
        logic [`SMD_WORD_W-1:0]   imm;
    } smd_req_t;

    // write-back bundle, write enables qualified by done
    typedef struct packed {
        logic                     wr_acc;
        logic                     wr_dx;
        logic                     wr_dst;
        logic                     wr_flags;
        logic                     carry_flag;
        logic                     overflow_flag;
        logic [`SMD_WORD_W-1:0]   accumulator_word;
        logic [`SMD_WORD_W-1:0]   data_extension_word;
        logic [`SMD_WORD_W-1:0]   dst;
    } smd_res_t;

endpackage : smd_pkg

// *** rtl/smd_divider.sv ***
`timescale 1ns/1ps
`include "smd_defines.svh"

// unsigned restoring divider, one quotient bit per clock
module smd_divider #(
    parameter int DVD_W = `SMD_DVD_W,
    parameter int DVS_W = `SMD_WORD_W
) (
    input  wire logic              i_clk,       // core clock
    input  wire logic              i_reset,     // synchronous reset, active high
    input  wire logic              i_start,     // load operands and begin
    input  wire logic [DVD_W-1:0]  i_dividend,  // dividend magnitude
    input  wire logic [DVS_W-1:0]  i_divisor,   // divisor magnitude, nonzero
    output logic                   o_done,      // one-cycle pulse, results valid
    output logic [DVD_W-1:0]       o_quotient,  // quotient magnitude
    output logic [DVS_W-1:0]       o_remainder  // remainder magnitude
);
    localparam int CNT_W = $clog2(DVD_W + 1);

    logic [DVS_W-1:0] rem_q;
    logic [DVD_W-1:0] quo_q;
    logic [DVS_W-1:0] dvs_q;
    logic [CNT_W-1:0] cnt_q;
    logic             done_q;

    wire [DVS_W:0] shifted = {rem_q[DVS_W-1:0], quo_q[DVD_W-1]};
    wire           take    = shifted >= {1'b0, dvs_q};
    wire [DVS_W:0] diff    = shifted - {1'b0, dvs_q};
    wire           running = cnt_q != '0;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rem_q  <= '0;
            quo_q  <= '0;
            dvs_q  <= '0;
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else if (i_start) begin
            rem_q  <= '0;
            quo_q  <= i_dividend;
            dvs_q  <= i_divisor;
            cnt_q  <= CNT_W'(DVD_W);
            done_q <= 1'b0;
        end else begin
            if (running) begin
                // what is kept is below the divisor, so the top bit is always clear
                rem_q <= take ? diff[DVS_W-1:0] : shifted[DVS_W-1:0];
                quo_q <= {quo_q[DVD_W-2:0], take};
                cnt_q <= cnt_q - 1'b1;
            end
            done_q <= cnt_q == CNT_W'(1);
        end
    end

    assign o_done      = done_q;
    assign o_quotient  = quo_q;
    assign o_remainder = rem_q;

endmodule : smd_divider

// *** rtl/smd_unit.sv ***
`timescale 1ns/1ps
`include "smd_defines.svh"

module smd_unit (
    input  wire logic              i_clk,        // core clock, 20 MHz
    input  wire logic              i_reset,      // synchronous reset, active high
    input  wire logic              i_start,      // request strobe, taken only when idle
    input  wire smd_pkg::smd_req_t i_req,        // operation and operands
    output logic                   o_busy,       // operation in flight
    output logic                   o_done,       // one-cycle pulse, operation finished
    output logic                   o_div_error,  // one-cycle pulse with done, divide error
    output logic [7:0]             o_int_vector, // vector to raise with divide error
    output smd_pkg::smd_res_t      o_result      // write-back, valid with done
);
    import smd_pkg::*;

    localparam int W  = `SMD_WORD_W;
    localparam int B  = `SMD_BYTE_W;
    localparam int DW = `SMD_DVD_W;

    smd_state_t       state_q;
    smd_state_t       state_d;
    smd_req_t         req_q;
    smd_res_t         res_q;
    smd_res_t         res_d;
    logic             done_q;
    logic             err_q;
    logic             busy_q;
    logic [7:0]       vec_q;
    logic             dvd_neg_q;
    logic             dvs_neg_q;

    function automatic logic [W-1:0] sext8(input logic [B-1:0] v);
        return {{(W-B){v[B-1]}}, v};
    endfunction : sext8

    function automatic logic op_is_div(input smd_op_t op);
        return (op == SMD_OP_DIV_B) || (op == SMD_OP_DIV_W);
    endfunction : op_is_div

    function automatic logic op_is_imm8(input smd_op_t op);
        return (op == SMD_OP_MUL2_I8) || (op == SMD_OP_MUL3_I8);
    endfunction : op_is_imm8

    // two's-complement magnitude or sign restore, shared by operands and results
    function automatic logic [DW-1:0] mag_dw(input logic neg, input logic [DW-1:0] v);
        return neg ? -v : v;
    endfunction : mag_dw

    function automatic logic [W-1:0] mag_w(input logic neg, input logic [W-1:0] v);
        return neg ? -v : v;
    endfunction : mag_w

    // ---------------- request acceptance ----------------
    // a strobe while busy is dropped: there is no queue
    wire idle   = state_q == SMD_ST_IDLE;
    wire accept = i_start & idle;

    // ---------------- divide operand preparation ----------------
    wire            new_div_b = i_req.op == SMD_OP_DIV_B;
    // byte form widens the accumulator word so one divider serves both widths
    wire [DW-1:0]   dvd_raw   = new_div_b
                              ? {{(DW-W){i_req.accumulator_word[W-1]}}, i_req.accumulator_word}
                              : {i_req.data_extension_word, i_req.accumulator_word};
    wire [W-1:0]    dvs_raw   = new_div_b ? sext8(i_req.src[B-1:0])
                                          : i_req.src;
    wire            dvd_neg   = dvd_raw[DW-1];
    wire            dvs_neg   = dvs_raw[W-1];
    // the divider sees magnitudes only; signs are put back on the way out
    wire [DW-1:0]   dvd_mag   = mag_dw(dvd_neg, dvd_raw);
    wire [W-1:0]    dvs_mag   = mag_w(dvs_neg, dvs_raw);
    // caught here because the divider would return an all-ones quotient
    wire            dvs_zero  = dvs_raw == `SMD_RST_WORD;
    wire            div_go    = accept & op_is_div(i_req.op) & ~dvs_zero;

    wire            div_done;
    wire [DW-1:0]   div_quo;
    wire [W-1:0]    div_rem;

    smd_divider #(
        .DVD_W (DW),
        .DVS_W (W)
    ) u_divider (
        .i_clk       (i_clk),
        .i_reset     (i_reset),
        .i_start     (div_go),
        .i_dividend  (dvd_mag),
        .i_divisor   (dvs_mag),
        .o_done      (div_done),
        .o_quotient  (div_quo),
        .o_remainder (div_rem)
    );

    // ---------------- divide result ----------------
    wire            div_b     = req_q.op == SMD_OP_DIV_B;
    wire            q_neg     = dvd_neg_q ^ dvs_neg_q;
    // magnitude division then sign fix gives truncation toward zero
    wire [DW-1:0]   q_lim_b   = q_neg ? `SMD_QMAX_NEG_B : `SMD_QMAX_POS_B;
    wire [DW-1:0]   q_lim_w   = q_neg ? `SMD_QMAX_NEG_W : `SMD_QMAX_POS_W;
    wire [DW-1:0]   q_lim     = div_b ? q_lim_b : q_lim_w;
    // a negative quotient may reach one step further than a positive one
    wire            q_ovf     = div_quo > q_lim;
    wire [W-1:0]    q_signed  = mag_w(q_neg, div_quo[W-1:0]);
    wire [W-1:0]    r_signed  = mag_w(dvd_neg_q, div_rem);
    wire            div_fin   = (state_q == SMD_ST_DIV) & div_done;

    // ---------------- multiply datapath ----------------
    wire            mul1_b    = req_q.op == SMD_OP_MUL1_B;
    wire            mul1_w    = req_q.op == SMD_OP_MUL1_W;
    wire            mul1      = mul1_b | mul1_w;
    wire            mul2      = (req_q.op == SMD_OP_MUL2_I8)
                              | (req_q.op == SMD_OP_MUL2_I16);
    wire [W-1:0]    imm_ext   = op_is_imm8(req_q.op) ? sext8(req_q.imm[B-1:0])
                                                     : req_q.imm;
    // byte form multiplies the sign-extended low bytes of source and accumulator
    wire [W-1:0]    acc_ext   = mul1_b ? sext8(req_q.accumulator_word[B-1:0])
                                       : req_q.accumulator_word;
    wire [W-1:0]    mul_src   = mul1_b ? sext8(req_q.src[B-1:0])
                                       : req_q.src;
    wire [W-1:0]    mcand     = mul2 ? req_q.dst : mul_src;
    wire [W-1:0]    mplier    = mul1 ? acc_ext : imm_ext;
    // both factors widened first, so the low double word of the product is exact
    wire [2*W-1:0]  mcand_x   = {{W{mcand[W-1]}}, mcand};
    wire [2*W-1:0]  mplier_x  = {{W{mplier[W-1]}}, mplier};
    wire [2*W-1:0]  product   = mcand_x * mplier_x;
    // byte product fits when its word equals the sign-extended low byte
    wire            fit_b     = product[W-1:0] == sext8(product[B-1:0]);
    // word product fits when the high word only repeats the sign
    wire            fit_w     = product[2*W-1:W] == {W{product[W-1]}};
    wire            mul_ovf   = mul1_b ? ~fit_b : ~fit_w;

    // ---------------- result assembly ----------------
    always_comb begin
        // data fields hold their last values; only the strobes fall back to zero
        res_d = res_q;
        res_d.wr_acc = 1'b0;
        res_d.wr_dx = 1'b0;
        res_d.wr_dst = 1'b0;
        res_d.wr_flags = 1'b0;
        case (state_q)
            SMD_ST_MUL: begin
                res_d.wr_flags = 1'b1;
                res_d.carry_flag = mul_ovf;
                res_d.overflow_flag = mul_ovf;
                if (mul1_b) begin
                    res_d.wr_acc = 1'b1;
                    res_d.accumulator_word = product[W-1:0];
                end else if (mul1_w) begin
                    res_d.wr_acc = 1'b1;
                    res_d.wr_dx = 1'b1;
                    res_d.accumulator_word = product[W-1:0];
                    res_d.data_extension_word = product[2*W-1:W];
                end else begin
                    // source stays untouched: only the destination and the flags are written
                    res_d.wr_dst = 1'b1;
                    res_d.dst = product[W-1:0];
                end
            end
            SMD_ST_DIV: begin
                // an overflowing quotient commits nothing and leaves flags alone
                // a successful divide leaves carry and overflow as they were
                if (div_done && !q_ovf) begin
                    if (div_b) begin
                        res_d.wr_acc = 1'b1;
                        res_d.accumulator_word = {r_signed[B-1:0], q_signed[B-1:0]};
                    end else begin
                        res_d.wr_acc = 1'b1;
                        res_d.wr_dx = 1'b1;
                        res_d.accumulator_word = q_signed;
                        res_d.data_extension_word = r_signed;
                    end
                end
            end
            default: begin
            end
        endcase
    end

    // ---------------- control ----------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            SMD_ST_IDLE: begin
                if (accept) begin
                    if (!op_is_div(i_req.op)) begin
                        state_d = SMD_ST_MUL;
                    end else if (dvs_zero) begin
                        // zero divisor reported at once, divider never runs
                        state_d = SMD_ST_ZERO;
                    end else begin
                        state_d = SMD_ST_DIV;
                    end
                end
            end
            SMD_ST_MUL: begin
                state_d = SMD_ST_IDLE;
            end
            SMD_ST_DIV: begin
                if (div_done) begin
                    state_d = SMD_ST_IDLE;
                end
            end
            SMD_ST_ZERO: begin
                state_d = SMD_ST_IDLE;
            end
            default: begin
                state_d = SMD_ST_IDLE;
            end
        endcase
    end

    // ---------------- completion ----------------
    // every path returns to idle within one done pulse, so busy never sticks
    wire mul_fin  = state_q == SMD_ST_MUL;
    wire zero_fin = state_q == SMD_ST_ZERO;
    wire done_d   = mul_fin | div_fin | zero_fin;
    wire err_d    = zero_fin | (div_fin & q_ovf);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_q <= SMD_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // the decoder may change its operands once a request is taken
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            req_q <= '0;
        end else if (accept) begin
            req_q <= i_req;
        end
    end

    // operand signs kept beside the request for the result sign fix
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            dvd_neg_q <= 1'b0;
            dvs_neg_q <= 1'b0;
        end else if (accept) begin
            dvd_neg_q <= dvd_neg;
            dvs_neg_q <= dvs_neg;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            res_q <= '0;
        end else begin
            res_q <= res_d;
        end
    end

    // done and error pulse together; the error never comes without done
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            done_q <= 1'b0;
            err_q  <= 1'b0;
        end else begin
            done_q <= done_d;
            err_q  <= err_d;
        end
    end

    // busy follows the next state so it drops in the same cycle as done rises
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= state_d != SMD_ST_IDLE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            vec_q <= `SMD_RST_VEC;
        end else begin
            vec_q <= `SMD_DIV_ERR_VEC;
        end
    end

    assign o_busy       = busy_q;
    assign o_done       = done_q;
    assign o_div_error  = err_q;
    assign o_int_vector = vec_q;
    assign o_result     = res_q;

endmodule : smd_unit

// *** tb/smd_unit_chk.sv ***
`timescale 1ns/1ps

module smd_unit_chk (
    input  wire logic              i_clk,        // core clock
    input  wire logic              i_reset,      // synchronous reset
    input  wire logic              i_start,      // request strobe
    input  wire smd_pkg::smd_req_t i_req,        // request
    input  wire logic              o_busy,       // in flight
    input  wire logic              o_done,       // finished pulse
    input  wire logic              o_div_error,  // divide error pulse
    input  wire logic [7:0]        o_int_vector, // vector
    input  wire smd_pkg::smd_res_t o_result      // write-back
);
    import smd_pkg::*;
    smd_req_t           cap_q;
    logic signed [31:0] prod;
    wire acc_w    = i_start && !o_busy;
    wire is_div   = (i_req.op == SMD_OP_DIV_B) || (i_req.op == SMD_OP_DIV_W);
    wire dvs_zero = (i_req.op == SMD_OP_DIV_B) ? (i_req.src[7:0] == 8'h00)
                                               : (i_req.src == 16'h0000);
    wire signed [15:0] mcand  = cap_q.op[1] ? cap_q.src : cap_q.dst;
    wire signed [15:0] mplier = cap_q.op[0] ? cap_q.imm
                                            : {{8{cap_q.imm[7]}}, cap_q.imm[7:0]};
    assign prod = mcand * mplier;
    wire prod_big = prod != {{16{prod[15]}}, prod[15:0]};
    wire any_wr   = o_result.wr_acc | o_result.wr_dx | o_result.wr_dst | o_result.wr_flags;

    // request is only sampled at accept, so keep it for result checks
    always_ff @(posedge i_clk) begin
        if (acc_w) begin
            cap_q <= i_req;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_mul_latency: assert property (acc_w && !is_div |=> o_busy ##1 (o_done && !o_busy && !o_div_error))
        else $error("multiply finished at the wrong cycle");
    a_div_latency: assert property (acc_w && is_div && !dvs_zero |-> ##33 o_busy ##1 (o_done && !o_busy))
        else $error("divide finished at the wrong cycle");
    a_zero_div_err: assert property (acc_w && is_div && dvs_zero |-> ##2 (o_done && o_div_error))
        else $error("zero divisor did not raise divide error");
    a_err_no_write: assert property (o_div_error |-> o_done && !any_wr)
        else $error("divide error came with a write");
    a_err_vector: assert property (o_div_error |-> o_int_vector == 8'h00)
        else $error("divide error vector not zero");
    a_wr_with_done: assert property (any_wr |-> o_done)
        else $error("write strobe outside done");
    a_mul1_flags: assert property (o_done && o_result.wr_flags && o_result.wr_dx |-> o_result.carry_flag == o_result.overflow_flag && o_result.carry_flag == (o_result.data_extension_word != {16{o_result.accumulator_word[15]}}))
        else $error("word multiply flags do not match product");
    a_rem_sign: assert property (o_done && o_result.wr_dx && !o_result.wr_flags |-> o_result.data_extension_word == 16'h0000 || o_result.data_extension_word[15] == cap_q.data_extension_word[15])
        else $error("remainder sign differs from dividend");
    a_mul23_low: assert property (o_done && o_result.wr_dst |-> o_result.dst == prod[15:0] && o_result.carry_flag == prod_big)
        else $error("destination product or flag wrong");

    c_div_err: cover property (o_div_error);
    c_mul_ovf: cover property (o_done && o_result.wr_dst && o_result.carry_flag);
    c_back2back: cover property (o_done && i_start);
endmodule : smd_unit_chk

bind smd_unit smd_unit_chk u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_start(i_start),
    .i_req(i_req), .o_busy(o_busy), .o_done(o_done), .o_div_error(o_div_error),
    .o_int_vector(o_int_vector), .o_result(o_result));

// *** tb/smd_regfile.sv ***
`timescale 1ns/1ps

// register file behind the unit: applies write-back strobes
module smd_regfile (
    input  wire logic              i_clk,    // core clock
    input  wire logic              i_reset,  // synchronous reset
    input  wire smd_pkg::smd_res_t i_result, // write-back bundle
    output logic [15:0]            o_acc,    // accumulator word
    output logic [15:0]            o_dx,     // extension word
    output logic [15:0]            o_dst     // destination register
);
    import smd_pkg::*;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_acc <= 16'h0000;
            o_dx  <= 16'h0000;
            o_dst <= 16'h0000;
        end else begin
            if (i_result.wr_acc) o_acc <= i_result.accumulator_word;
            if (i_result.wr_dx) o_dx <= i_result.data_extension_word;
            if (i_result.wr_dst) o_dst <= i_result.dst;
        end
    end
endmodule : smd_regfile

// *** tb/tb_signed_mul_div_unit.sv ***
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fails++; \
    $display("[ERR] %s exp=%h got=%h", nm, ex, got); end end

module tb_signed_mul_div_unit;
    import smd_pkg::*;
    logic        i_clk, i_reset, i_start, o_busy, o_done, o_div_error;
    logic [7:0]  o_int_vector;
    logic [15:0] rf_acc, rf_dx, rf_dst;
    smd_req_t    i_req;
    smd_res_t    o_result;
    int          fails, comparisons;
    logic [31:0] seed = 32'h00015ae7;

    smd_unit DUT (.i_clk(i_clk), .i_reset(i_reset), .i_start(i_start), .i_req(i_req),
        .o_busy(o_busy), .o_done(o_done), .o_div_error(o_div_error),
        .o_int_vector(o_int_vector), .o_result(o_result));
    smd_regfile u_rf (.i_clk(i_clk), .i_reset(i_reset), .i_result(o_result),
        .o_acc(rf_acc), .o_dx(rf_dx), .o_dst(rf_dst));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // expected write-back worked out with wide signed arithmetic
    function automatic smd_res_t expect_of(input smd_req_t r, output logic err);
        longint a, b, q, m, lim;
        smd_res_t e;
        e = '0;
        err = 1'b0;
        if (r.op == SMD_OP_DIV_B || r.op == SMD_OP_DIV_W) begin
            a = (r.op == SMD_OP_DIV_B) ? $signed(r.accumulator_word)
                : $signed({r.data_extension_word, r.accumulator_word});
            b = (r.op == SMD_OP_DIV_B) ? $signed(r.src[7:0]) : $signed(r.src);
            lim = (r.op == SMD_OP_DIV_B) ? 128 : 32768;
            if (b == 0) err = 1'b1;
            else begin
                q = a / b;
                m = a % b;
                err = (q >= lim) || (q < -lim);
            end
            if (!err && r.op == SMD_OP_DIV_B) begin
                e.wr_acc = 1'b1;
                e.accumulator_word = {m[7:0], q[7:0]};
            end else if (!err) begin
                {e.wr_acc, e.wr_dx} = 2'b11;
                e.accumulator_word = q[15:0];
                e.data_extension_word = m[15:0];
            end
        end else begin
            lim = (r.op == SMD_OP_MUL1_B) ? 128 : 32768;
            case (r.op)
                SMD_OP_MUL1_B: begin a = $signed(r.src[7:0]); b = $signed(r.accumulator_word[7:0]); end
                SMD_OP_MUL1_W: begin a = $signed(r.src); b = $signed(r.accumulator_word); end
                default: begin
                    a = r.op[1] ? $signed(r.src) : $signed(r.dst);
                    b = r.op[0] ? $signed(r.imm) : $signed(r.imm[7:0]);
                end
            endcase
            m = a * b;
            e.wr_flags = 1'b1;
            e.carry_flag = (m >= lim) || (m < -lim);
            e.overflow_flag = e.carry_flag;
            e.accumulator_word = m[15:0];
            e.data_extension_word = m[31:16];
            e.dst = m[15:0];
            e.wr_acc = (r.op == SMD_OP_MUL1_B) || (r.op == SMD_OP_MUL1_W);
            e.wr_dx = (r.op == SMD_OP_MUL1_W);
            e.wr_dst = r.op[2];
        end
        return e;
    endfunction : expect_of

    // one operation; busy cycles carry ignored strobes with junk operands
    task automatic run(input smd_req_t r);
        smd_res_t    e;
        logic        err;
        int          n;
        logic [95:0] junk;
        e = expect_of(r, err);
        i_req = r;
        i_start = 1'b1;
        @(negedge i_clk);
        i_start = 1'b0;
        n = 1;
        while (o_done !== 1'b1 && n < 60) begin
            junk = {rnd(), rnd(), rnd()};
            i_start = o_busy & junk[95];
            i_req = junk[$bits(smd_req_t)-1:0];
            @(negedge i_clk);
            n++;
        end
        `CHK("latency", (!err || r.op[0] ? r.src : r.src[7:0]) != 0 && !r.op[2:1] ? 34 : 2, n)
        `CHK("div_error", err, o_div_error)
        `CHK("wr_bits", {e.wr_acc, e.wr_dx, e.wr_dst, e.wr_flags}, {o_result.wr_acc, o_result.wr_dx, o_result.wr_dst, o_result.wr_flags})
        if (e.wr_acc) `CHK("acc", e.accumulator_word, o_result.accumulator_word)
        if (e.wr_dx) `CHK("dx", e.data_extension_word, o_result.data_extension_word)
        if (e.wr_dst) `CHK("dst", e.dst, o_result.dst)
        if (e.wr_flags) `CHK("flags", {e.carry_flag, e.overflow_flag}, {o_result.carry_flag, o_result.overflow_flag})
    endtask : run

    task automatic summarize();
        if (fails == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    initial begin
        repeat (30000) @(posedge i_clk);
        fails++;
        summarize();
    end

    smd_req_t corner[10] = '{
        '{SMD_OP_DIV_B, 16'hc75c, 16'h0000, 16'h007b, 16'h0000, 16'h0000},
        '{SMD_OP_DIV_W, 16'h12c0, 16'h0000, 16'hfebf, 16'h0000, 16'h0000},
        '{SMD_OP_DIV_B, 16'h1234, 16'h0000, 16'hff00, 16'h0000, 16'h0000},
        '{SMD_OP_DIV_W, 16'h1234, 16'h0001, 16'h0000, 16'h0000, 16'h0000},
        '{SMD_OP_DIV_B, 16'h8000, 16'h0000, 16'h00ff, 16'h0000, 16'h0000},
        '{SMD_OP_DIV_B, 16'hff80, 16'h0000, 16'h0001, 16'h0000, 16'h0000},
        '{SMD_OP_DIV_W, 16'h0000, 16'h8000, 16'hffff, 16'h0000, 16'h0000},
        '{SMD_OP_MUL1_B, 16'h0007, 16'h0000, 16'h00f6, 16'h0000, 16'h0000},
        '{SMD_OP_MUL2_I8, 16'h0000, 16'h0000, 16'h0000, 16'h4000, 16'h0080},
        '{SMD_OP_MUL3_I16, 16'h0000, 16'h0000, 16'h7fff, 16'h0000, 16'h7fff}};

    initial begin
        smd_req_t r;
        logic [31:0] x;
        fails = 0;
        comparisons = 0;
        i_reset = 1'b1;
        i_start = 1'b0;
        i_req = '0;
        repeat (16) @(negedge i_clk);
        i_reset = 1'b0;
        foreach (corner[k]) run(corner[k]);
        // reset in the middle of a divide drops it and commits nothing
        i_req = corner[1];
        i_start = 1'b1;
        @(negedge i_clk);
        i_start = 1'b0;
        repeat (4) @(negedge i_clk);
        i_reset = 1'b1;
        @(negedge i_clk);
        `CHK("reset_out", 11'h000, {o_busy, o_done, o_div_error, o_int_vector})
        `CHK("reset_res", {$bits(smd_res_t){1'b0}}, o_result)
        i_reset = 1'b0;
        repeat (300) begin
            x = rnd();
            r.op = smd_op_t'(x[2:0]);
            r.accumulator_word = x[3] ? rf_acc : 16'(rnd());
            r.data_extension_word = x[4] ? {16{r.accumulator_word[15]}} : rf_dx;
            r.src = (x[8:5] == 4'h0) ? 16'h0000 : 16'(rnd());
            r.dst = x[9] ? rf_dst : 16'(rnd());
            r.imm = 16'(rnd());
            run(r);
        end
        summarize();
    end
endmodule : tb_signed_mul_div_unit
